/* logic/bnk1_pkg.sv */
// Constants for the bank-one special register block
package bnk1_pkg;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    localparam int          ADDR_IDX_LSB   = 2;
    localparam int          ADDR_IDX_MSB   = 9;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ     = 2'h3;
    localparam logic [2:0]  HSIZE_WORD     = 3'h2;
    localparam logic        HRESP_OKAY     = 1'b0;
    localparam logic [23:0] RDATA_PAD      = 24'h00_0000;
    localparam logic [7:0]  IDX_NONE       = 8'h00;
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;

    // ****************************************************************
    // Register indexes (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0]  IDX_INDIRECT_ACCESS_PORT = 8'h80;
    localparam int          NREG                     = 17;
    localparam int          SLOT_W                   = 5;

    // Storage slots, in index order
    localparam int SLOT_OPTION    = 0;
    localparam int SLOT_PC_LOW    = 1;
    localparam int SLOT_STATUS    = 2;
    localparam int SLOT_IND_PTR   = 3;
    localparam int SLOT_DIR_A     = 4;
    localparam int SLOT_DIR_B     = 5;
    localparam int SLOT_DIR_C     = 6;
    localparam int SLOT_DIR_D     = 7;
    localparam int SLOT_DIR_E     = 8;
    localparam int SLOT_PC_HIGH   = 9;
    localparam int SLOT_IRQ_CTRL  = 10;
    localparam int SLOT_PERIPH_IE = 11;
    localparam int SLOT_POWER     = 12;
    localparam int SLOT_T2_PERIOD = 13;
    localparam int SLOT_SER_ADDR  = 14;
    localparam int SLOT_SER_STAT  = 15;
    localparam int SLOT_ADC       = 16;

    localparam logic [7:0] REG_IDX [NREG] = '{
        8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89,
        8'h8a, 8'h8b, 8'h8c, 8'h8e, 8'h92, 8'h93, 8'h94, 8'h9f};
    // Implemented bits; all others read as zero, except the serial status flags at 94
    localparam logic [7:0] REG_IMPL [NREG] = '{
        8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h3f, 8'hff, 8'hff,
        8'h1f, 8'hff, 8'hcf, 8'h02, 8'hff, 8'hff, 8'hc0, 8'h07};
    // Bits software may write
    localparam logic [7:0] REG_WRITE [NREG] = '{
        8'hff, 8'hff, 8'he7, 8'hff, 8'h3f, 8'hff, 8'h3f, 8'hff, 8'hff,
        8'h1f, 8'hff, 8'hcf, 8'h02, 8'hff, 8'hff, 8'hc0, 8'h07};
    // Power-on values; unknown bits come up zero
    localparam logic [7:0] REG_POR [NREG] = '{
        8'hff, 8'h00, 8'h18, 8'h00, 8'h3f, 8'hff, 8'h3f, 8'hff, 8'hff,
        8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
    // Values on every other reset
    localparam logic [7:0] REG_WARM [NREG] = '{
        8'hff, 8'h00, 8'h00, 8'h00, 8'h3f, 8'hff, 8'h3f, 8'hff, 8'hff,
        8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
    // Bits kept through the other resets
    localparam logic [7:0] REG_KEEP [NREG] = '{
        8'h00, 8'h00, 8'h07, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};

    // ****************************************************************
    // Field layouts
    // ****************************************************************
    localparam logic [7:0] STATUS_COND_MASK = 8'h18;
    localparam int         STATUS_TO_BIT    = 4;
    localparam int         STATUS_PD_BIT    = 3;
    localparam logic [7:0] IRQ_CTRL_HWSET   = 8'h07;
    localparam logic [2:0] IRQ_SET_NONE     = 3'h0;
    localparam logic [7:0] SSP_FLAG_MASK    = 8'h3f;
    localparam int         ADC_IRQ_ENABLE_BIT = 6;

endpackage

/* logic/bnk1_reg_cell.sv */
// One byte register with power-on, other-reset and hardware-set behaviour
`timescale 1ns/1ps
`default_nettype none
module bnk1_reg_cell import bnk1_pkg::*; #(
    parameter logic [7:0] IMPL  = 8'hff,
    parameter logic [7:0] WMASK = 8'hff,
    parameter logic [7:0] POR   = 8'h00,
    parameter logic [7:0] WARM  = 8'h00,
    parameter logic [7:0] KEEP  = 8'h00,
    parameter logic [7:0] COND  = 8'h00,
    parameter logic [7:0] HWSET = 8'h00
) (
    // Clock and resets
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       ce,
    input  wire logic       warm_reset,
    // Access
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic [7:0] cond_val,
    input  wire logic [7:0] hw_set,
    output logic      [7:0] q
);

    logic [7:0] q_r;
    logic [7:0] q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (warm_reset) begin
            q_nxt = ((WARM & ~KEEP & ~COND) | (q_r & KEEP)
                    | (cond_val & COND)) & IMPL;
        end else begin
            if (wr_en) begin
                q_nxt = (q_r & ~WMASK) | (wr_data & WMASK & IMPL);
            end
            // Hardware set after the write so a set is never lost to a write; an other reset drops it
            q_nxt = q_nxt | (hw_set & HWSET & IMPL);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_r <= POR & IMPL;
        end else if (ce) begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule
`default_nettype wire

/* logic/bnk1_ahb_slave.sv */
// AHB-Lite slave front end for the byte register bank
`timescale 1ns/1ps
`default_nettype none
module bnk1_ahb_slave import bnk1_pkg::*; (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Register side
    output logic             wr_en,
    output logic      [7:0]  acc_idx,
    output logic      [7:0]  wr_data,
    input  wire logic [7:0]  rd_data
);

    typedef enum logic [1:0] {SL_IDLE, SL_WRITE, SL_READ, SL_RDONE}
        bnk1_slv_e;

    bnk1_slv_e   st_r;
    bnk1_slv_e   st_nxt;
    logic [7:0]  idx_r;
    logic [7:0]  idx_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        take;
    logic        hit;

    assign take = hsel && hready
               && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    // Only aligned whole words inside the index range reach a register
    assign hit = (haddr[31:ADDR_IDX_MSB+1] == '0)
              && (haddr[ADDR_IDX_LSB-1:0] == '0) && (hsize == HSIZE_WORD);

    always_comb begin
        st_nxt    = st_r;
        idx_nxt   = idx_r;
        rdata_nxt = rdata_r;
        case (st_r)
            SL_READ: begin
                rdata_nxt = {RDATA_PAD, rd_data};
                st_nxt    = SL_RDONE;
            end
            default: begin
                st_nxt = SL_IDLE;
                if (take) begin
                    st_nxt  = hwrite ? SL_WRITE : SL_READ;
                    idx_nxt = hit ? haddr[ADDR_IDX_MSB:ADDR_IDX_LSB]
                                  : IDX_NONE;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r    <= SL_IDLE;
            idx_r   <= IDX_NONE;
            rdata_r <= '0;
        end else if (ce) begin
            st_r    <= st_nxt;
            idx_r   <= idx_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Frozen clock enable stalls the bus rather than dropping a transfer
    assign hreadyout = ce && (st_r != SL_READ);
    assign hresp     = HRESP_OKAY;
    assign hrdata    = rdata_r;
    assign wr_en     = ce && (st_r == SL_WRITE);
    assign acc_idx   = idx_r;
    assign wr_data   = hwdata[7:0];

endmodule
`default_nettype wire

/* logic/bnk1_special_regs.sv */
// Bank-one special function register decode and storage
`timescale 1ns/1ps
`default_nettype none
module bnk1_special_regs import bnk1_pkg::*; #(
    parameter logic HAS_ADC = 1'b1
) (
    // Clock, clock enable, resets
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        warm_reset,
    // AHB-Lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Reset cause and hardware flags from the core
    input  wire logic        wake_cause_timeout,
    input  wire logic        wake_cause_powerdown,
    input  wire logic [2:0]  irq_flag_set,
    input  wire logic [5:0]  serial_status_flags,
    // Register contents to the core
    output logic      [7:0]  timer0_pullup_option,
    output logic      [7:0]  program_counter_low,
    output logic      [7:0]  cpu_status_flags,
    output logic      [7:0]  indirect_pointer,
    output logic      [7:0]  port_a_direction,
    output logic      [7:0]  port_b_direction,
    output logic      [7:0]  port_c_direction,
    output logic      [7:0]  port_d_direction,
    output logic      [7:0]  port_e_direction,
    output logic      [7:0]  pc_high_latch,
    output logic      [7:0]  interrupt_control,
    output logic      [7:0]  peripheral_irq_enable,
    output logic      [7:0]  power_control,
    output logic      [7:0]  timer2_period,
    output logic      [7:0]  serial_slave_address,
    output logic      [7:0]  serial_port_status,
    output logic      [7:0]  adc_port_config
);

    // ****************************************************************
    // Decode
    // ****************************************************************

    // Slot of an index, or NREG when nothing is stored there
    function automatic logic [SLOT_W-1:0] find_slot(input logic [7:0] idx);
        logic [SLOT_W-1:0] s;
        s = SLOT_W'(NREG);
        for (int i = 0; i < NREG; i++) begin
            if (REG_IDX[i] == idx) begin
                s = SLOT_W'(i);
            end
        end
        return s;
    endfunction

    logic                     bus_wr_en;
    logic [7:0]               acc_idx;
    logic [7:0]               bus_wr_data;
    logic [7:0]               rd_byte;
    logic [SLOT_W-1:0]        acc_slot;
    logic                     acc_mapped;
    logic [NREG-1:0][7:0]     q_all;
    logic [NREG-1:0][7:0]     impl_eff;
    logic [7:0]               status_cond;
    logic [7:0]               interrupt_control_set;

    bnk1_ahb_slave u_slave (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .wr_en     (bus_wr_en),
        .acc_idx   (acc_idx),
        .wr_data   (bus_wr_data),
        .rd_data   (rd_byte)
    );

    assign acc_slot   = find_slot(acc_idx);
    assign acc_mapped = (acc_slot != SLOT_W'(NREG));

    // ****************************************************************
    // Storage
    // ****************************************************************

    always_comb begin
        status_cond                = BYTE_ZERO;
        status_cond[STATUS_TO_BIT] = wake_cause_timeout;
        status_cond[STATUS_PD_BIT] = wake_cause_powerdown;
        interrupt_control_set                 = {5'h00, irq_flag_set};
    end

    for (genvar g = 0; g < NREG; g++) begin : g_reg
        // Converter-less part has no storage behind its port config
        localparam logic [7:0] IMPL_G =
            (g == SLOT_ADC && !HAS_ADC) ? BYTE_ZERO : REG_IMPL[g];
        localparam logic [7:0] COND_G =
            (g == SLOT_STATUS) ? STATUS_COND_MASK : BYTE_ZERO;
        localparam logic [7:0] HWSET_G =
            (g == SLOT_IRQ_CTRL) ? IRQ_CTRL_HWSET : BYTE_ZERO;
        logic wr_g;

        // Write reaches a slot only on an exact index match
        assign wr_g = bus_wr_en && (acc_slot == SLOT_W'(g));
        assign impl_eff[g] = IMPL_G;

        bnk1_reg_cell #(
            .IMPL  (IMPL_G),
            .WMASK (REG_WRITE[g]),
            .POR   (REG_POR[g]),
            .WARM  (REG_WARM[g]),
            .KEEP  (REG_KEEP[g]),
            .COND  (COND_G),
            .HWSET (HWSET_G)
        ) u_cell (
            .hclk       (hclk),
            .hresetn    (hresetn),
            .ce         (ce),
            .warm_reset (warm_reset),
            .wr_en      (wr_g),
            .wr_data    (bus_wr_data),
            .cond_val   (status_cond),
            .hw_set     (interrupt_control_set),
            .q          (q_all[g])
        );
    end

    // ****************************************************************
    // Read path
    // ****************************************************************

    always_comb begin
        rd_byte = BYTE_ZERO;
        if (acc_mapped) begin
            rd_byte = q_all[acc_slot] & impl_eff[acc_slot];
            if (acc_slot == SLOT_W'(SLOT_SER_STAT)) begin
                rd_byte = rd_byte
                        | ({2'b00, serial_status_flags} & SSP_FLAG_MASK);
            end
        end
        // Indirect port is decode only; the core resolves the target
        if (acc_idx == IDX_INDIRECT_ACCESS_PORT) begin
            rd_byte = BYTE_ZERO;
        end
    end

    // ****************************************************************
    // Outputs to the core
    // ****************************************************************

    assign timer0_pullup_option  = q_all[SLOT_OPTION];
    assign program_counter_low   = q_all[SLOT_PC_LOW];
    assign cpu_status_flags      = q_all[SLOT_STATUS];
    assign indirect_pointer      = q_all[SLOT_IND_PTR];
    assign port_a_direction      = q_all[SLOT_DIR_A];
    assign port_b_direction      = q_all[SLOT_DIR_B];
    assign port_c_direction      = q_all[SLOT_DIR_C];
    assign port_d_direction      = q_all[SLOT_DIR_D];
    assign port_e_direction      = q_all[SLOT_DIR_E];
    assign pc_high_latch         = q_all[SLOT_PC_HIGH];
    assign interrupt_control     = q_all[SLOT_IRQ_CTRL];
    // Software must keep the converter enable clear on the smaller part
    assign peripheral_irq_enable = q_all[SLOT_PERIPH_IE];
    assign power_control         = q_all[SLOT_POWER];
    assign timer2_period         = q_all[SLOT_T2_PERIOD];
    assign serial_slave_address  = q_all[SLOT_SER_ADDR];
    assign serial_port_status    = q_all[SLOT_SER_STAT]
                                 | ({2'b00, serial_status_flags}
                                    & SSP_FLAG_MASK);
    assign adc_port_config       = q_all[SLOT_ADC];

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic any_unimpl;
    always_comb begin
        any_unimpl = 1'b0;
        for (int i = 0; i < NREG; i++) begin
            any_unimpl = any_unimpl | (|(q_all[i] & ~impl_eff[i]));
        end
    end

    unimpl_bits_zero_a: assert property (
        !any_unimpl)
        else $error("unimplemented bit holds a one");

    unmapped_read_zero_a: assert property (
        !acc_mapped |-> rd_byte == BYTE_ZERO)
        else $error("unmapped location read nonzero");

    warm_values_a: assert property (
        ce && warm_reset |=> timer0_pullup_option == REG_WARM[SLOT_OPTION]
            && port_a_direction == REG_WARM[SLOT_DIR_A]
            && timer2_period == REG_WARM[SLOT_T2_PERIOD]
            && cpu_status_flags[7:5] == 3'h0)
        else $error("other reset value not loaded");

    warm_keep_a: assert property (
        ce && warm_reset |=> indirect_pointer == $past(indirect_pointer)
            && cpu_status_flags[2:0] == $past(cpu_status_flags[2:0]))
        else $error("unchanged bits altered by reset");

    warm_cause_a: assert property (
        ce && warm_reset |=>
            cpu_status_flags[STATUS_TO_BIT] == $past(wake_cause_timeout)
            && cpu_status_flags[STATUS_PD_BIT] == $past(wake_cause_powerdown))
        else $error("conditional status bits wrong");

    no_adc_zero_a: assert property (
        !HAS_ADC |-> adc_port_config == BYTE_ZERO)
        else $error("port config present without converter");

    stray_write_a: assert property (
        bus_wr_en && !acc_mapped && !warm_reset && irq_flag_set == IRQ_SET_NONE
            |=> q_all == $past(q_all))
        else $error("write to empty location changed state");

    tris_masked_a: assert property (
        bus_wr_en && acc_slot == SLOT_W'(SLOT_DIR_A) && !warm_reset
            |=> port_a_direction == ($past(bus_wr_data) & REG_IMPL[SLOT_DIR_A]))
        else $error("direction write not masked");

    flag_set_wins_a: assert property (
        ce && !warm_reset && irq_flag_set[0] |=> interrupt_control[0])
        else $error("hardware flag set lost");

    warm_reset_c: cover property (ce && warm_reset ##1 !warm_reset);
    period_write_c: cover property (
        bus_wr_en && acc_slot == SLOT_W'(SLOT_T2_PERIOD));
    empty_read_c: cover property (!acc_mapped && !hreadyout ##1 hreadyout);

endmodule
`default_nettype wire

/* testbench/bnk1_special_regs_tb.sv */
// Self-checking bench for the bank-one special register block
`timescale 1ns/1ps
`default_nettype none
module bnk1_special_regs_tb import bnk1_pkg::*;;

    // ****************************************************************
    // Signals
    // ****************************************************************
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] por;
        logic [7:0] wval;
        logic [7:0] rback;
        logic [7:0] zread;
    } bnk1_row_s;

    // Index, power-on value, write value, read after it, read after zero
    localparam int        NROW = 24;
    localparam bnk1_row_s ROWS [NROW] = '{
        '{8'h80, 8'h00, 8'hff, 8'h00, 8'h00},
        '{8'h81, 8'hff, 8'hff, 8'hff, 8'h00},
        '{8'h82, 8'h00, 8'hff, 8'hff, 8'h00},
        '{8'h83, 8'h18, 8'hff, 8'hff, 8'h18},
        '{8'h84, 8'h00, 8'hff, 8'hff, 8'h00},
        '{8'h85, 8'h3f, 8'hff, 8'h3f, 8'h00},
        '{8'h86, 8'hff, 8'hff, 8'hff, 8'h00},
        '{8'h87, 8'h3f, 8'hff, 8'h3f, 8'h00},
        '{8'h88, 8'hff, 8'hff, 8'hff, 8'h00},
        '{8'h89, 8'hff, 8'hff, 8'hff, 8'h00},
        '{8'h8a, 8'h00, 8'hff, 8'h1f, 8'h00},
        '{8'h8b, 8'h00, 8'hff, 8'hff, 8'h00},
        '{8'h8c, 8'h00, 8'hbf, 8'h8f, 8'h00},
        '{8'h8d, 8'h00, 8'hff, 8'h00, 8'h00},
        '{8'h8e, 8'h00, 8'hff, 8'h02, 8'h00},
        '{8'h8f, 8'h00, 8'hff, 8'h00, 8'h00},
        '{8'h90, 8'h00, 8'hff, 8'h00, 8'h00},
        '{8'h91, 8'h00, 8'hff, 8'h00, 8'h00},
        '{8'h92, 8'hff, 8'hff, 8'hff, 8'h00},
        '{8'h93, 8'h00, 8'hff, 8'hff, 8'h00},
        '{8'h94, 8'h00, 8'hff, 8'hc0, 8'h00},
        '{8'h95, 8'h00, 8'hff, 8'h00, 8'h00},
        '{8'h9e, 8'h00, 8'hff, 8'h00, 8'h00},
        '{8'h9f, 8'h00, 8'hff, 8'h07, 8'h00}};

    logic        hclk;
    logic        hresetn;
    logic        ce;
    logic        warm_reset;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
    logic        wake_cause_timeout;
    logic        wake_cause_powerdown;
    logic [2:0]  irq_flag_set;
    logic [5:0]  serial_status_flags;
    logic        rdy_v   [2];
    logic [31:0] rdata_v [2];
    logic        hresp_v [2];
    logic [7:0]  stat_v  [2];
    logic [7:0]  ser_v   [2];
    logic [31:0] r0;
    logic [31:0] r1;
    int          n_mismatch;
    int          comparisons;

    // Two slaves on the bus: the ready of device 0 is the bus ready
    assign hready = rdy_v[0];

    always #2.5 hclk = ~hclk;

    // ****************************************************************
    // Devices: index 0 with converter, index 1 without
    // ****************************************************************
    for (genvar g = 0; g < 2; g++) begin : g_dut
        bnk1_special_regs #(.HAS_ADC(g == 0)) i_dut (
            .hclk(hclk), .hresetn(hresetn), .ce(ce),
            .warm_reset(warm_reset), .hsel(hsel), .haddr(haddr),
            .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
            .hready(hready), .hwdata(hwdata), .hreadyout(rdy_v[g]),
            .hresp(hresp_v[g]), .hrdata(rdata_v[g]),
            .wake_cause_timeout(wake_cause_timeout),
            .wake_cause_powerdown(wake_cause_powerdown),
            .irq_flag_set(irq_flag_set),
            .serial_status_flags(serial_status_flags),
            .timer0_pullup_option(), .program_counter_low(),
            .cpu_status_flags(stat_v[g]), .indirect_pointer(),
            .port_a_direction(), .port_b_direction(),
            .port_c_direction(), .port_d_direction(),
            .port_e_direction(), .pc_high_latch(),
            .interrupt_control(), .peripheral_irq_enable(),
            .power_control(), .timer2_period(),
            .serial_slave_address(), .serial_port_status(ser_v[g]),
            .adc_port_config());
    end

    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task automatic bus_wait();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        if (hready !== 1'b1) begin
            n_mismatch++;
            $display("unexpected hready expected 1 seen %b", hready);
            summarize();
        end
    endtask

    // One single word transfer; both devices answer the same request
    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [7:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        hsize  <= HSIZE_WORD;
        htrans <= HTRANS_NONSEQ;
        bus_wait();
        htrans <= 2'h0;
        hwdata <= {RDATA_PAD, d};
        bus_wait();
        r0 = rdata_v[0];
        r1 = rdata_v[1];
    endtask

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== {RDATA_PAD, exp}) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus({22'h00_0000, idx, 2'h0}, 1'b1, d);
    endtask

    // The part without converter must show zero at 9f
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        bus({22'h00_0000, idx, 2'h0}, 1'b0, BYTE_ZERO);
        check("hrdata", exp, r0);
        check("hrdata_lite", (idx == 8'h9f) ? BYTE_ZERO : exp, r1);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Cuts a hung run short
    initial begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        $display("unexpected run length expected 20000 seen more");
        summarize();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        ce = 1'b1;
        warm_reset = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0000_0000;
        wake_cause_timeout = 1'b0;
        wake_cause_powerdown = 1'b0;
        irq_flag_set = 3'h0;
        serial_status_flags = 6'h00;
        n_mismatch = 0;
        comparisons = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);

        foreach (ROWS[i]) begin
            rd(ROWS[i].idx, ROWS[i].por);
            wr(ROWS[i].idx, ROWS[i].wval);
            rd(ROWS[i].idx, ROWS[i].rback);
            wr(ROWS[i].idx, 8'h00);
            rd(ROWS[i].idx, ROWS[i].zread);
        end
        $display("test register table done");

        // Out-of-range and misaligned addresses alias nothing
        bus(32'h0000_0604, 1'b1, 8'hff);
        bus(32'h0000_0205, 1'b1, 8'hff);
        bus(32'h0000_0604, 1'b0, 8'h00);
        check("hrdata_alias", 8'h00, r0);
        rd(8'h81, 8'h00);
        $display("test unmapped address done");

        wr(8'h84, 8'ha5);
        wr(8'h8e, 8'h02);
        wr(8'h83, 8'h07);
        wr(8'h8b, 8'hf8);
        irq_flag_set <= 3'h1;
        @(posedge hclk);
        irq_flag_set <= 3'h0;
        rd(8'h8b, 8'hf9);
        wr(8'h92, 8'h12);
        wr(8'h86, 8'h00);
        wr(8'h8a, 8'h1f);
        wr(8'h9f, 8'h05);
        wr(8'h94, 8'hc0);
        wake_cause_timeout <= 1'b1;
        serial_status_flags <= 6'h2a;
        warm_reset <= 1'b1;
        @(posedge hclk);
        warm_reset <= 1'b0;
        @(posedge hclk);
        rd(8'h84, 8'ha5);
        rd(8'h8e, 8'h02);
        rd(8'h83, 8'h17);
        rd(8'h8b, 8'h01);
        rd(8'h92, 8'hff);
        rd(8'h86, 8'hff);
        rd(8'h8a, 8'h00);
        rd(8'h9f, 8'h00);
        rd(8'h94, 8'h2a);
        check("cpu_status_flags", 8'h17, {RDATA_PAD, stat_v[0]});
        check("serial_port_status", 8'h2a, {RDATA_PAD, ser_v[0]});
        check("hresp", 8'h00, {31'h0000_0000, hresp_v[0]});
        $display("test other reset done");

        // Power-on reset in mid-run drops the kept bits too
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(8'h84, 8'h00);
        rd(8'h8e, 8'h00);
        rd(8'h83, 8'h18);
        rd(8'h8b, 8'h00);
        rd(8'h86, 8'hff);
        check("cpu_status_flags", 8'h18, {RDATA_PAD, stat_v[0]});
        $display("test power-on reset done");
        summarize();
    end

endmodule
`default_nettype wire
